// >>> core/cdps_top.sv
`timescale 1ns/1ps
// Behaviour
// - duty correction gives 50% odd and even
// - stage phase from start-high and offset
// - second stages and divider four fields
// - phase value weights start-high by sixteen
// - phase delay per case, stages add
// - per-output ramp, fraction and bypass fields
// - ramp current and capacitor count
// - fine delay from range, fraction, offset
// - excessive delay stops that output
// - hold outputs static, release together
// - soft sync, soft reset, distribution power-down
// - power-up, reset pin, sleep pin sync
// - calibration holds sync until done
// - fifteen cycles from pin release
// - one cycle release uncertainty tolerated
// - soft sync acts after update write
// - static level from start-high bit
// - outputs sharing a divider sync together
// - excluded channel keeps toggling
// - soft reset bits written, then cleared
module cdps_top
   import cdps_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [cdps_pkg::CDPS_AW-1:0] reg_addr,
   input wire logic [cdps_pkg::CDPS_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [cdps_pkg::CDPS_DW-1:0] reg_rdata,
   // sync sources
   input wire logic sync_pin_n,
   input wire logic sleep_pin_n,
   input wire logic vco_cal_busy,
   // fine delay analog side
   input wire logic [cdps_pkg::CDPS_NOUT-1:0] delay_over_half,
   output logic [cdps_pkg::CDPS_NOUT-1:0] delay_bypass,
   output logic [cdps_pkg::CDPS_NOUT*11-1:0] ramp_current_ua,
   output logic [cdps_pkg::CDPS_NOUT*3-1:0] ramp_cap_count,
   output logic [cdps_pkg::CDPS_NOUT*6-1:0] delay_fraction,
   // clock outputs a to d
   output logic [cdps_pkg::CDPS_NOUT-1:0] lvds_cmos_output,
   output logic [cdps_pkg::CDPS_NOUT-1:0] half_cycle_ext,
   output logic sync_active
);
   function automatic logic [4:0] cdps_reg_idx(input logic [9:0] addr);
      logic [4:0] idx;
      idx = CDPS_IDX_NONE;
      for (int i = 0; i < CDPS_NREG; i++)
      begin
         if (addr == CDPS_ADDR_TBL[i])
         begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction : cdps_reg_idx

   function automatic logic [2:0] cdps_zero_count(input logic [2:0] caps);
      return 3'({2'b00, ~caps[0]} + {2'b00, ~caps[1]} + {2'b00, ~caps[2]});
   endfunction : cdps_zero_count

   logic [7:0] shd_reg [CDPS_NREG];
   logic [7:0] act_reg [CDPS_NREG];
   logic [7:0] serial_cfg_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic por_reg;
   logic in_lvl_reg;
   logic [3:0] rel_cnt_reg;
   logic [3:0] rel_cnt_next;
   cdps_state_e state_reg;
   cdps_state_e state_next;
   logic [CDPS_NOUT-1:0] out_reg;
   logic [CDPS_NOUT-1:0] stop_reg;
   wire logic [4:0] wr_idx;
   wire logic [4:0] rd_idx;
   wire logic upd_wr;
   wire logic cfg_wr;
   wire logic soft_rst;
   wire logic sync_src;
   wire logic hold_all;
   wire logic [1:0] div_level;
   wire logic [1:0] div_ext;
   wire logic [1:0] div_excl;

   assign wr_idx = cdps_reg_idx(reg_addr);
   assign rd_idx = cdps_reg_idx(reg_addr);
   assign upd_wr = reg_wr && (reg_addr == CDPS_ADDR_UPDATE) && reg_wdata[CDPS_UPDATE_BIT];
   assign cfg_wr = reg_wr && (reg_addr == CDPS_ADDR_SERIAL_CFG);
   // either mirrored bit holds soft reset, no update needed
   assign soft_rst = serial_cfg_reg[CDPS_SOFT_RST_BIT] | serial_cfg_reg[CDPS_SOFT_RST_MIRROR_BIT];

   // shadow on write, active on update
   generate
      for (genvar r = 0; r < CDPS_NREG; r++)
      begin : g_reg
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               shd_reg[r] <= CDPS_RESET_VAL;
               act_reg[r] <= CDPS_RESET_VAL;
            end
            else if (soft_rst)
            begin
               shd_reg[r] <= CDPS_RESET_VAL;
               act_reg[r] <= CDPS_RESET_VAL;
            end
            else
            begin
               if (reg_wr && wr_idx == 5'(r))
               begin
                  shd_reg[r] <= reg_wdata;
               end
               // soft sync bit moves only on update or soft reset
               if (upd_wr)
               begin
                  act_reg[r] <= shd_reg[r];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_cfg_reg <= CDPS_RESET_VAL;
      end
      else if (cfg_wr)
      begin
         serial_cfg_reg <= reg_wdata;
      end
   end

   always_comb
   begin
      rdata_next = 8'h00;
      if (rd_idx != CDPS_IDX_NONE)
      begin
         rdata_next = shd_reg[rd_idx];
      end
      else if (reg_addr == CDPS_ADDR_SERIAL_CFG)
      begin
         rdata_next = serial_cfg_reg;
      end
      else if (reg_addr == CDPS_ADDR_STATUS)
      begin
         rdata_next = {2'b00, stop_reg, pin_s2_reg, hold_all};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_reg <= 8'h00;
      end
      else if (reg_rd)
      begin
         rdata_reg <= rdata_next;
      end
      else
      begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
         por_reg <= 1'b1;
         in_lvl_reg <= 1'b0;
      end
      else
      begin
         pin_s1_reg <= sync_pin_n;
         pin_s2_reg <= pin_s1_reg;
         // one power-up sync after reset release
         por_reg <= 1'b0;
         in_lvl_reg <= ~in_lvl_reg;
      end
   end

   assign sync_src = ~pin_s2_reg | act_reg[CDPS_IDX_DIST_CTL][CDPS_SOFT_SYNC_BIT]
      | act_reg[CDPS_IDX_DIST_CTL][CDPS_DIST_PD_BIT] | soft_rst | ~sleep_pin_n | vco_cal_busy | por_reg;

   always_comb
   begin
      state_next = state_reg;
      rel_cnt_next = rel_cnt_reg;
      case (state_reg)
         CDPS_ST_IDLE:
         begin
            if (sync_src)
            begin
               state_next = CDPS_ST_HOLD;
            end
         end
         CDPS_ST_HOLD:
         begin
            if (!sync_src)
            begin
               state_next = CDPS_ST_RELEASE;
               rel_cnt_next = CDPS_REL_LOAD;
            end
         end
         CDPS_ST_RELEASE:
         begin
            if (sync_src)
            begin
               state_next = CDPS_ST_HOLD;
            end
            else if (rel_cnt_reg == 4'h0)
            begin
               state_next = CDPS_ST_IDLE;
            end
            else
            begin
               rel_cnt_next = rel_cnt_reg - 4'h1;
            end
         end
         default:
         begin
            state_next = CDPS_ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= CDPS_ST_HOLD;
         rel_cnt_reg <= 4'h0;
      end
      else
      begin
         state_reg <= state_next;
         rel_cnt_reg <= rel_cnt_next;
      end
   end

   // one hold for all channels not excluded, common release
   assign hold_all = (state_reg != CDPS_ST_IDLE);
   assign sync_active = hold_all;

   generate
      for (genvar d = 0; d < 2; d++)
      begin : g_div
         localparam int BASE = CDPS_IDX_DIV_BASE + d * CDPS_IDX_DIV_STEP;
         wire logic [7:0] ctl = act_reg[CDPS_IDX_DIV_CTL + d];
         wire logic div_hold;
         wire logic lvl1;
         wire logic tick1;
         wire logic ext1;
         wire logic ext2;
         assign div_excl[d] = ctl[CDPS_CTL_EXCLUDE_BIT];
         assign div_hold = hold_all & ~div_excl[d];
         cdps_stage u_first
         (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .in_ce(1'b1),
            .in_level(in_lvl_reg),
            .hold(div_hold),
            .bypass(ctl[CDPS_CTL_BYP1_BIT]),
            .dcc_on(~ctl[CDPS_CTL_DCC_DIS_BIT]),
            .low_cnt(act_reg[BASE][7:4]),
            .high_cnt(act_reg[BASE][3:0]),
            .initial_level_high(act_reg[BASE + 3][0]),
            .coarse_phase_value(act_reg[BASE + 1][3:0]),
            .out_level(lvl1),
            .out_tick(tick1),
            .half_ext(ext1)
         );
         // second stage delay adds in its input periods
         cdps_stage u_second
         (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .in_ce(tick1),
            .in_level(lvl1),
            .hold(div_hold),
            .bypass(ctl[CDPS_CTL_BYP2_BIT]),
            .dcc_on(~ctl[CDPS_CTL_DCC_DIS_BIT]),
            .low_cnt(act_reg[BASE + 2][7:4]),
            .high_cnt(act_reg[BASE + 2][3:0]),
            .initial_level_high(act_reg[BASE + 3][1]),
            .coarse_phase_value(act_reg[BASE + 1][7:4]),
            .out_level(div_level[d]),
            .out_tick(),
            .half_ext(ext2)
         );
         assign div_ext[d] = ctl[CDPS_CTL_BYP2_BIT] ? ext1 : ext2;
      end
   endgenerate

   generate
      for (genvar o = 0; o < CDPS_NOUT; o++)
      begin : g_out
         localparam int OB = CDPS_IDX_OUT_BASE + 3 * o;
         wire logic [2:0] cur_code = act_reg[OB + 1][CDPS_RAMP_CUR_LSB +: 3];
         assign delay_bypass[o] = act_reg[OB][CDPS_BYPASS_BIT];
         assign ramp_current_ua[o*11 +: 11] = 11'(CDPS_RAMP_STEP_UA * ({8'h00, cur_code} + 11'd1));
         assign ramp_cap_count[o*3 +: 3] =
            3'(cdps_zero_count(act_reg[OB + 1][CDPS_RAMP_CAP_LSB +: 3]) + 3'h1);
         // analog delay uses range, fraction/63, offset
         assign delay_fraction[o*6 +: 6] = act_reg[OB + 2][5:0];

         // divider pair drives outputs, stalled when too long
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               out_reg[o] <= 1'b0;
               stop_reg[o] <= 1'b0;
            end
            else
            begin
               stop_reg[o] <= delay_over_half[o] & ~act_reg[OB][CDPS_BYPASS_BIT];
               if (!(delay_over_half[o] && !act_reg[OB][CDPS_BYPASS_BIT]))
               begin
                  out_reg[o] <= div_level[o / 2];
               end
            end
         end
         assign half_cycle_ext[o] = div_ext[o / 2];
      end
   endgenerate
   assign lvds_cmos_output = out_reg;

   sequence s_release_start;
      (state_reg == CDPS_ST_HOLD) ##1 (state_reg == CDPS_ST_RELEASE && rel_cnt_reg == CDPS_REL_LOAD);
   endsequence

   property p_release_len;
      @(posedge sys_clk) disable iff (!rst_n)
      s_release_start ##0 (!sync_src) [*7] ##1 (!sync_src) [*6] |=> (state_reg == CDPS_ST_IDLE);
   endproperty
   a_release_len: assert property (p_release_len) else $error("release latency wrong");

   property p_pin_sync;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == CDPS_ST_IDLE && !sync_pin_n) |-> ##3 hold_all;
   endproperty
   a_pin_sync: assert property (p_pin_sync) else $error("sync pin low not held");

   property p_soft_rst_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      soft_rst |=> hold_all;
   endproperty
   a_soft_rst_hold: assert property (p_soft_rst_hold) else $error("soft reset did not hold outputs");

   property p_cal_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      vco_cal_busy |=> (hold_all && state_reg != CDPS_ST_RELEASE);
   endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("calibration did not hold sync");

   property p_shadow_only;
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && wr_idx == 5'(CDPS_IDX_DIST_CTL) && !upd_wr && !soft_rst)
      |=> $stable(act_reg[CDPS_IDX_DIST_CTL]);
   endproperty
   a_shadow_only: assert property (p_shadow_only) else $error("active setting changed without update");

   property p_update_copy;
      @(posedge sys_clk) disable iff (!rst_n)
      (upd_wr && !soft_rst) |=> (act_reg[CDPS_IDX_DIST_CTL] == $past(shd_reg[CDPS_IDX_DIST_CTL]));
   endproperty
   a_update_copy: assert property (p_update_copy) else $error("update did not copy shadow");

   property p_stop_freeze;
      @(posedge sys_clk) disable iff (!rst_n)
      (delay_over_half[0] && !delay_bypass[0]) |=> $stable(lvds_cmos_output[0]);
   endproperty
   a_stop_freeze: assert property (p_stop_freeze) else $error("too-long delay output kept toggling");

   property p_read_once;
      @(posedge sys_clk) disable iff (!rst_n)
      !reg_rd |=> (reg_rdata == 8'h00);
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data outside answer cycle");
endmodule : cdps_top

// >>> common/cdps_pkg.sv
package cdps_pkg;
   localparam int CDPS_AW = 10;
   localparam int CDPS_DW = 8;
   localparam int CDPS_NREG = 23;
   localparam int CDPS_NOUT = 4;
   // index of an unmapped address
   localparam logic [4:0] CDPS_IDX_NONE = 5'h1F;
   // printed offsets of the shadowed registers, in index order
   localparam logic [9:0] CDPS_ADDR_TBL [CDPS_NREG] = '{
      10'h0A0, 10'h0A1, 10'h0A2, 10'h0A3, 10'h0A4, 10'h0A5,
      10'h0A6, 10'h0A7, 10'h0A8, 10'h0A9, 10'h0AA, 10'h0AB,
      10'h199, 10'h19A, 10'h19B, 10'h19C,
      10'h19E, 10'h19F, 10'h1A0, 10'h1A1,
      10'h230, 10'h1A4, 10'h1A5};
   localparam int CDPS_IDX_OUT_BASE = 0;
   localparam int CDPS_IDX_DIV_BASE = 12;
   localparam int CDPS_IDX_DIV_STEP = 4;
   localparam int CDPS_IDX_DIST_CTL = 20;
   localparam int CDPS_IDX_DIV_CTL = 21;
   localparam logic [9:0] CDPS_ADDR_SERIAL_CFG = 10'h000;
   localparam logic [9:0] CDPS_ADDR_UPDATE = 10'h232;
   localparam logic [9:0] CDPS_ADDR_STATUS = 10'h1A6;
   localparam logic [7:0] CDPS_RESET_VAL = 8'h00;
   // field positions
   localparam int CDPS_SOFT_RST_BIT = 5;
   localparam int CDPS_SOFT_RST_MIRROR_BIT = 2;
   localparam int CDPS_UPDATE_BIT = 0;
   localparam int CDPS_SOFT_SYNC_BIT = 0;
   localparam int CDPS_DIST_PD_BIT = 1;
   localparam int CDPS_CTL_EXCLUDE_BIT = 0;
   localparam int CDPS_CTL_DCC_DIS_BIT = 1;
   localparam int CDPS_CTL_BYP1_BIT = 2;
   localparam int CDPS_CTL_BYP2_BIT = 3;
   localparam int CDPS_BYPASS_BIT = 0;
   localparam int CDPS_RAMP_CUR_LSB = 0;
   localparam int CDPS_RAMP_CAP_LSB = 3;
   localparam int CDPS_PHASE_SH_WEIGHT = 16;
   localparam int CDPS_PHASE_MAX_DIRECT = 15;
   localparam logic [10:0] CDPS_RAMP_STEP_UA = 11'd200;
   localparam logic [5:0] CDPS_FRACTION_MAX = 6'h2F;
   // sync release: 14 channel-divider input cycles plus one extra cycle
   localparam int CDPS_SYNC_BASE_CYC = 14;
   localparam int CDPS_SYNC_EXTRA_CYC = 1;
   localparam int CDPS_SYNC_LAT_CYC = CDPS_SYNC_BASE_CYC + CDPS_SYNC_EXTRA_CYC;
   // two synchroniser flops and one state step already spent
   localparam logic [3:0] CDPS_REL_LOAD = 4'(CDPS_SYNC_LAT_CYC - 3);
   typedef enum logic [2:0]
   {
      CDPS_ST_IDLE = 3'b001,
      CDPS_ST_HOLD = 3'b010,
      CDPS_ST_RELEASE = 3'b100
   } cdps_state_e;
endpackage : cdps_pkg

// >>> core/cdps_stage.sv
`timescale 1ns/1ps
module cdps_stage
   import cdps_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // input clock of this stage
   input wire logic in_ce,
   input wire logic in_level,
   // settings
   input wire logic hold,
   input wire logic bypass,
   input wire logic dcc_on,
   input wire logic [3:0] low_cnt,
   input wire logic [3:0] high_cnt,
   input wire logic initial_level_high,
   input wire logic [3:0] coarse_phase_value,
   // divided clock
   output logic out_level,
   output logic out_tick,
   output logic half_ext
);
   logic lvl_reg;
   logic lvl_next;
   logic wait_reg;
   logic wait_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   wire logic [4:0] phase_val;
   wire logic [4:0] start_dly;
   wire logic cnt_zero;

   assign phase_val = {initial_level_high, coarse_phase_value};
   assign start_dly = (phase_val <= 5'(CDPS_PHASE_MAX_DIRECT)) ? phase_val :
      5'(phase_val - 5'(CDPS_PHASE_SH_WEIGHT) + {1'b0, low_cnt} + 5'h01);
   assign cnt_zero = (cnt_reg == 5'h00);
   // odd divide gets a half-cycle falling-edge shift
   assign half_ext = dcc_on & ~bypass & (low_cnt[0] ^ high_cnt[0]);
   // bypassed stage passes its input unchanged
   assign out_level = bypass ? in_level : lvl_reg;
   assign out_tick = bypass ? in_ce : (in_ce & ~hold & ~wait_reg & cnt_zero & ~lvl_reg);

   always_comb
   begin
      lvl_next = lvl_reg;
      wait_next = wait_reg;
      cnt_next = cnt_reg;
      if (hold)
      begin
         lvl_next = initial_level_high;
         wait_next = 1'b1;
         cnt_next = start_dly;
      end
      else if (in_ce && wait_reg)
      begin
         if (cnt_zero)
         begin
            wait_next = 1'b0;
            lvl_next = 1'b1;
            cnt_next = {1'b0, high_cnt};
         end
         else
         begin
            cnt_next = cnt_reg - 5'h01;
         end
      end
      else if (in_ce)
      begin
         // high for N+1, low for M+1 periods
         if (cnt_zero)
         begin
            lvl_next = ~lvl_reg;
            cnt_next = lvl_reg ? {1'b0, low_cnt} : {1'b0, high_cnt};
         end
         else
         begin
            cnt_next = cnt_reg - 5'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lvl_reg <= 1'b0;
         wait_reg <= 1'b1;
         cnt_reg <= 5'h00;
      end
      else
      begin
         lvl_reg <= lvl_next;
         wait_reg <= wait_next;
         cnt_reg <= cnt_next;
      end
   end

   property p_hold_static;
      @(posedge sys_clk) disable iff (!rst_n)
      hold |=> (lvl_reg == $past(initial_level_high));
   endproperty
   a_hold_static: assert property (p_hold_static) else $error("static level differs from start-high");

   property p_phase_zero_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (hold && !bypass && phase_val == 5'h00 && in_ce) ##1 (!hold && in_ce) |=> lvl_reg;
   endproperty
   a_phase_zero_start: assert property (p_phase_zero_start) else $error("zero phase did not start high");

   property p_high_time;
      @(posedge sys_clk) disable iff (!rst_n)
      (!hold && !wait_reg && in_ce && cnt_zero && !lvl_reg && high_cnt == 4'h1 && $stable(high_cnt))
      ##1 (in_ce && !hold) |=> lvl_reg;
   endproperty
   a_high_time: assert property (p_high_time) else $error("high phase ended too early");
endmodule : cdps_stage

// >>> dv/cdps_pin_host.sv
`timescale 1ns/1ps
module cdps_pin_host
   import cdps_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bench commands
   input wire logic cmd_sync,
   input wire logic cmd_sleep,
   input wire logic cmd_cal,
   input wire logic [cdps_pkg::CDPS_NOUT-1:0] cmd_over,
   // pins toward the block
   output logic sync_pin_n,
   output logic sleep_pin_n,
   output logic vco_cal_busy,
   output logic [cdps_pkg::CDPS_NOUT-1:0] delay_over_half
);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_pin_n <= 1'b1;
         sleep_pin_n <= 1'b1;
         vco_cal_busy <= 1'b0;
         delay_over_half <= '0;
      end
      else
      begin
         sync_pin_n <= ~cmd_sync;
         sleep_pin_n <= ~cmd_sleep;
         vco_cal_busy <= cmd_cal;
         delay_over_half <= cmd_over;
      end
   end
endmodule : cdps_pin_host

// >>> dv/cascaded_divider_phase_sync_tb.sv
`timescale 1ns/1ps
module cascaded_divider_phase_sync_tb;
   import cdps_pkg::*;
   logic sys_clk, rst_n, reg_wr, reg_rd, sync_active;
   logic [CDPS_AW-1:0] reg_addr;
   logic [CDPS_DW-1:0] reg_wdata, reg_rdata, d;
   logic cmd_sync, cmd_sleep, cmd_cal, sync_pin_n, sleep_pin_n, vco_cal_busy;
   logic [CDPS_NOUT-1:0] cmd_over, delay_over_half, delay_bypass, lvds_cmos_output, half_cycle_ext;
   logic [CDPS_NOUT*11-1:0] ramp_current_ua;
   logic [CDPS_NOUT*3-1:0] ramp_cap_count;
   logic [CDPS_NOUT*6-1:0] delay_fraction;
   int n_mismatch, num_checks, c, t;

   cdps_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin_n(sync_pin_n),
      .sleep_pin_n(sleep_pin_n), .vco_cal_busy(vco_cal_busy), .delay_over_half(delay_over_half),
      .delay_bypass(delay_bypass), .ramp_current_ua(ramp_current_ua), .ramp_cap_count(ramp_cap_count),
      .delay_fraction(delay_fraction), .lvds_cmos_output(lvds_cmos_output),
      .half_cycle_ext(half_cycle_ext), .sync_active(sync_active));
   cdps_pin_host i_host (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_sync(cmd_sync), .cmd_sleep(cmd_sleep),
      .cmd_cal(cmd_cal), .cmd_over(cmd_over), .sync_pin_n(sync_pin_n), .sleep_pin_n(sleep_pin_n),
      .vco_cal_busy(vco_cal_busy), .delay_over_half(delay_over_half));

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string name, input logic [43:0] exp, input logic [43:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   // update write copies shadow to active
   task automatic upd();
      wr(CDPS_ADDR_UPDATE, 8'h01);
      repeat (2) @(posedge sys_clk);
   endtask : upd

   task automatic wait_idle(output int n);
      n = 0;
      while (sync_active !== 1'b0 && n < 100)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : wait_idle

   task automatic toggles(input int b, input int len, output int n);
      logic last;
      n = 0;
      last = lvds_cmos_output[b];
      repeat (len)
      begin
         @(posedge sys_clk);
         #1;
         if (lvds_cmos_output[b] !== last) n++;
         last = lvds_cmos_output[b];
      end
   endtask : toggles

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      #80000;
      n_mismatch++;
      wrap_up();
   end

   initial
   begin
      {rst_n, reg_wr, reg_rd, cmd_sync, cmd_sleep, cmd_cal} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      cmd_over = '0;
      repeat (6) @(posedge sys_clk);
      chk("sync_in_reset", 1, sync_active);
      rst_n <= 1'b1;
      wait_idle(c);
      chk("powerup_sync_ends", 1, c > 0 && c < 40);
      wr(10'h199, 8'h11);
      rd(10'h199, d);
      chk("div3_first_counts", 8'h11, d);
      rd(10'h3FF, d);
      chk("unmapped_read", 0, d);
      // fine delay settings, fraction kept at the supported top
      wr(10'h0A4, 8'h2A);
      wr(10'h0A5, 8'h2F);
      wr(10'h0A3, 8'h01);
      wr(10'h0AA, 8'h3F);
      #1;
      chk("ramp_b_before_update", 200, ramp_current_ua[21:11]);
      upd();
      chk("ramp_b_current", 600, ramp_current_ua[21:11]);
      chk("ramp_b_caps", 2, ramp_cap_count[5:3]);
      chk("fraction_b", 6'h2F, delay_fraction[11:6]);
      chk("bypass_b", 1, delay_bypass[1]);
      chk("ramp_d_current", 1600, ramp_current_ua[43:33]);
      chk("ramp_d_caps", 1, ramp_cap_count[11:9]);
      // dividers by four per stage, divider 3 second stage starts high
      wr(10'h19B, 8'h11);
      wr(10'h19E, 8'h11);
      wr(10'h1A0, 8'h11);
      wr(10'h19C, 8'h02);
      upd();
      chk("half_ext_even", 0, half_cycle_ext);
      toggles(0, 64, t);
      chk("out_a_runs", 1, t > 0);
      // soft sync waits for the update write
      wr(10'h230, 8'h01);
      repeat (3) @(posedge sys_clk);
      chk("sync_before_update", 0, sync_active);
      upd();
      chk("soft_sync_active", 1, sync_active);
      repeat (3) @(posedge sys_clk);
      toggles(0, 32, t);
      chk("out_a_held", 0, t);
      chk("held_levels", 4'h3, lvds_cmos_output);
      rd(CDPS_ADDR_STATUS, d);
      chk("status_held", 8'h03, d);
      // exclude divider 4 while sync holds
      wr(10'h1A5, 8'h01);
      upd();
      toggles(2, 64, t);
      chk("excluded_c_runs", 1, t > 0);
      chk("out_ab_still_held", 2'h3, lvds_cmos_output[1:0]);
      wr(10'h230, 8'h00);
      upd();
      wait_idle(c);
      chk("soft_sync_release", 1, c < 20);
      wr(10'h1A5, 8'h00);
      upd();
      // manual sync on the pin
      @(posedge sys_clk);
      cmd_sync <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk("pin_sync_active", 1, sync_active);
      cmd_sync <= 1'b0;
      @(posedge sync_pin_n);
      wait_idle(c);
      chk("pin_release_cycles", 1, c >= 14 && c <= 16);
      // distribution power-down pulse
      wr(10'h230, 8'h02);
      upd();
      chk("dist_pd_sync", 1, sync_active);
      wr(10'h230, 8'h00);
      upd();
      wait_idle(c);
      chk("dist_pd_release", 1, c < 20);
      // sleep pin pulse
      @(posedge sys_clk);
      cmd_sleep <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("sleep_sync", 1, sync_active);
      cmd_sleep <= 1'b0;
      repeat (2) @(posedge sys_clk);
      wait_idle(c);
      chk("sleep_release", 1, c < 20);
      // calibration holds sync until done
      @(posedge sys_clk);
      cmd_cal <= 1'b1;
      repeat (40) @(posedge sys_clk);
      chk("cal_holds_sync", 1, sync_active);
      cmd_cal <= 1'b0;
      repeat (2) @(posedge sys_clk);
      wait_idle(c);
      chk("cal_release", 1, c < 20);
      // over-long fine delay stops output a only
      @(posedge sys_clk);
      cmd_over <= 4'h1;
      repeat (3) @(posedge sys_clk);
      toggles(0, 64, t);
      chk("out_a_stopped", 0, t);
      toggles(2, 64, t);
      chk("out_c_runs", 1, t > 0);
      cmd_over <= 4'h0;
      // odd first stage alone on divider 3
      wr(10'h199, 8'h10);
      wr(10'h1A4, 8'h08);
      upd();
      chk("half_ext_odd", 4'h3, half_cycle_ext);
      // soft reset clears settings and syncs
      wr(CDPS_ADDR_SERIAL_CFG, 8'h24);
      repeat (2) @(posedge sys_clk);
      chk("soft_reset_sync", 1, sync_active);
      rd(10'h199, d);
      chk("reg_cleared", CDPS_RESET_VAL, d);
      wr(CDPS_ADDR_SERIAL_CFG, 8'h00);
      wait_idle(c);
      chk("soft_reset_release", 1, c < 30);
      wrap_up();
   end
endmodule : cascaded_divider_phase_sync_tb
